// [shared/mcw_pkg.sv]
// constants, register map and field layout of the multi-counter watchdog control block
`default_nettype none
package mcw_pkg;
   // byte offsets of the registers
   localparam logic [7:0] OFF_CNT_LOW = 8'h00;
   localparam logic [7:0] OFF_CNT_HIGH = 8'h04;
   localparam logic [7:0] OFF_MATCH = 8'h08;
   localparam logic [7:0] OFF_CONFIG = 8'h0C;
   localparam logic [7:0] OFF_CTL = 8'h10;
   localparam logic [7:0] OFF_INTR = 8'h14;
   // configuration fields
   localparam int CFG_IRQ0 = 0;
   localparam int CFG_CLR0 = 2;
   localparam int CFG_CHAIN01 = 3;
   localparam int CFG_IRQ1 = 8;
   localparam int CFG_CLR1 = 10;
   localparam int CFG_CHAIN12 = 11;
   localparam int CFG_MODE2 = 16;
   localparam int CFG_BITS2_LSB = 24;
   localparam int BITS2_W = 5;
   localparam logic [31:0] CFG_WMASK = 32'h1F010F0F;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [31:0] MATCH_RESET = 32'h00000000;
   // control fields, one byte per counter
   localparam int CTL_STRIDE = 8;
   localparam int CTL_EN = 0;
   localparam int CTL_ENSTAT = 1;
   localparam int CTL_CLR = 3;
   localparam int CTL_LOCK_LSB = 30;
   localparam int NUM_CTR = 3;
   localparam logic [1:0] LOCK_NONE = 2'h0;
   localparam logic [1:0] LOCK_CLR_B0 = 2'h1;
   localparam logic [1:0] LOCK_CLR_B1 = 2'h2;
   localparam logic [1:0] LOCK_SET_ALL = 2'h3;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: low-frequency period derived into system clock cycles
   localparam int SYS_PERIOD_NS = 10;
   localparam int LF_PERIOD_NS = 30518;
   localparam int LF_DIV_CYCLES = LF_PERIOD_NS / SYS_PERIOD_NS;
   localparam int EN_SETTLE_TICKS = 2;
endpackage
`default_nettype wire

// [hdl/mcw_short_ctr.sv]
// one 16-bit watchdog counter with clear-on-compare and clear request
`default_nettype none
module mcw_short_ctr
   import mcw_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_tick,
   input wire logic i_run,
   input wire logic i_step,
   input wire logic i_clear,
   input wire logic [WIDTH-1:0] i_cmp,
   input wire logic i_clr_on_cmp,
   output logic [WIDTH-1:0] o_count,
   output logic o_hit
);
   initial begin
      if (WIDTH < 1 || WIDTH > 32) $error("mcw_short_ctr: WIDTH out of range");
   end

   // compare match while the counter sits at its compare value
   assign o_hit = (o_count == i_cmp);

   // counting advances only on the slow tick
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_count <= '0;
      end else if (i_tick) begin
         if (i_clear) begin
            o_count <= '0;
         end else if (i_run && i_step) begin
            if (o_hit && i_clr_on_cmp) begin
               o_count <= '0;
            end else begin
               o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// [hdl/mcw_ctl.sv]
// multi-counter watchdog: counters, enables, clears, write lock and chaining behind an axi4-lite slave
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module mcw_ctl
   import mcw_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int LF_DIV = LF_DIV_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic [2:0] i_s_axi_awprot,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input wire logic [2:0] i_s_axi_arprot,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic [NUM_CTR-1:0] o_counter_irq_flag,
   output logic [NUM_CTR-1:0] o_counter_enabled_status
);
   initial begin
      if (ADDR_W < 8) $error("mcw_ctl: ADDR_W below 8");
      if (LF_DIV < 2 || LF_DIV > 4095) $error("mcw_ctl: LF_DIV out of range");
   end

   logic [11:0] lf_div_cnt;
   logic lf_tick;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] wmask;
   logic wr_fire;
   logic wr_ok;
   logic [1:0] lock;
   logic locked;
   logic wr_cfg;
   logic wr_match;
   logic wr_ctl;
   logic wr_intr;
   logic [31:0] cfg;
   logic [31:0] cmp;
   logic [NUM_CTR-1:0] en_bit;
   logic [NUM_CTR-1:0] en_s1;
   logic [NUM_CTR-1:0] act_en;
   logic [NUM_CTR-1:0] clr_req;
   logic [NUM_CTR-1:0] clr_set;
   logic [NUM_CTR-1:0] irq_set;
   logic [NUM_CTR-1:0] irq_clr;
   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic [31:0] wide;
   logic [31:0] next_wide;
   logic hit0;
   logic hit1;
   logic hit0_q;
   logic hit1_q;
   logic step1;
   logic step2;
   logic [BITS2_W-1:0] bit_sel;
   logic toggle;
   logic [31:0] ctl_view;
   logic [31:0] next_rdata;
   logic next_rok;

   // slow tick: one-cycle enable pulse every LF_DIV system cycles
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         lf_div_cnt <= '0;
      end else if (lf_div_cnt == 12'(LF_DIV - 1)) begin
         lf_div_cnt <= '0;
      end else begin
         lf_div_cnt <= lf_div_cnt + 12'h001;
      end
   end
   assign lf_tick = (lf_div_cnt == 12'(LF_DIV - 1));

   // write address and data are taken independently and held until both are present
   assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
   assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= i_s_axi_awaddr[7:0];
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= i_s_axi_wdata;
            w_strb_q <= i_s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write decode; protected registers drop the write while locked
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign locked = (lock != LOCK_NONE);
   always_comb begin
      wr_ok = 1'b1;
      if (aw_addr_q == OFF_CNT_LOW) begin
         wr_ok = 1'b1;
      end else if (aw_addr_q == OFF_CNT_HIGH) begin
         wr_ok = 1'b1;
      end else if (aw_addr_q == OFF_MATCH) begin
         wr_ok = 1'b1;
      end else if (aw_addr_q == OFF_CONFIG) begin
         wr_ok = 1'b1;
      end else if (aw_addr_q == OFF_CTL) begin
         wr_ok = 1'b1;
      end else if (aw_addr_q == OFF_INTR) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end
   assign wr_cfg = wr_fire && (aw_addr_q == OFF_CONFIG) && !locked;
   assign wr_match = wr_fire && (aw_addr_q == OFF_MATCH) && !locked;
   assign wr_ctl = wr_fire && (aw_addr_q == OFF_CTL) && !locked;
   assign wr_intr = wr_fire && (aw_addr_q == OFF_INTR);

   // configuration and compare registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cfg <= CFG_RESET;
         cmp <= MATCH_RESET;
      end else begin
         if (wr_cfg) begin
            cfg <= ((cfg & ~wmask) | (w_data_q & wmask)) & CFG_WMASK;
         end
         if (wr_match) begin
            cmp <= (cmp & ~wmask) | (w_data_q & wmask);
         end
      end
   end

   // lock field: clear-by-code, set-both, ignores lock state itself
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         lock <= LOCK_NONE;
      end else if (wr_fire && (aw_addr_q == OFF_CTL) && w_strb_q[3]) begin
         case (w_data_q[CTL_LOCK_LSB +: 2])
            LOCK_CLR_B0: lock[0] <= 1'b0;
            LOCK_CLR_B1: lock[1] <= 1'b0;
            LOCK_SET_ALL: lock <= LOCK_SET_ALL;
            default: lock <= lock;
         endcase
      end
   end

   // enable bits, their two-tick settling pipeline and clear requests
   always_comb begin
      for (int i = 0; i < NUM_CTR; i++) begin
         clr_set[i] = wr_ctl && w_strb_q[(i*CTL_STRIDE)/8] && w_data_q[i*CTL_STRIDE + CTL_CLR];
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         en_bit <= '0;
         en_s1 <= '0;
         act_en <= '0;
         clr_req <= '0;
      end else begin
         for (int i = 0; i < NUM_CTR; i++) begin
            if (wr_ctl && w_strb_q[(i*CTL_STRIDE)/8]) begin
               en_bit[i] <= w_data_q[i*CTL_STRIDE + CTL_EN];
            end
            if (clr_set[i]) begin
               clr_req[i] <= 1'b1;
            end else if (lf_tick) begin
               clr_req[i] <= 1'b0;
            end
         end
         if (lf_tick) begin
            en_s1 <= en_bit;
            act_en <= en_s1;
         end
      end
   end
   assign o_counter_enabled_status = act_en;

   // the two short counters; chained upper steps on the delayed prescaler match
   assign step1 = cfg[CFG_CHAIN01] ? hit0_q : 1'b1;
   assign step2 = cfg[CFG_CHAIN12] ? hit1_q : 1'b1;
   mcw_short_ctr #(.WIDTH(16)) u_first (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_tick(lf_tick),
      .i_run(act_en[0]),
      .i_step(1'b1),
      .i_clear(clr_req[0]),
      .i_cmp(cmp[15:0]),
      .i_clr_on_cmp(cfg[CFG_CLR0]),
      .o_count(cnt0),
      .o_hit(hit0)
   );
   mcw_short_ctr #(.WIDTH(16)) u_second (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_tick(lf_tick),
      .i_run(act_en[1]),
      .i_step(step1),
      .i_clear(clr_req[1]),
      .i_cmp(cmp[31:16]),
      .i_clr_on_cmp(cfg[CFG_CLR1]),
      .o_count(cnt1),
      .o_hit(hit1)
   );

   // match seen at one tick feeds the upper counter at the next; a clear does not cancel it
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         hit0_q <= 1'b0;
         hit1_q <= 1'b0;
      end else if (lf_tick) begin
         hit0_q <= hit0 && act_en[0];
         hit1_q <= hit1 && act_en[1] && step1;
      end
   end

   // wide counter and its toggle watch
   assign next_wide = wide + 32'h00000001;
   assign bit_sel = cfg[CFG_BITS2_LSB +: BITS2_W];
   assign toggle = wide[bit_sel] ^ next_wide[bit_sel];
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         wide <= 32'h00000000;
      end else if (lf_tick) begin
         if (clr_req[2]) begin
            wide <= 32'h00000000;
         end else if (act_en[2] && step2) begin
            wide <= next_wide;
         end
      end
   end

   // sticky flags: set wins over a software write of 1
   assign irq_set[0] = lf_tick && act_en[0] && !clr_req[0] && hit0 && cfg[CFG_IRQ0];
   assign irq_set[1] = lf_tick && act_en[1] && !clr_req[1] && hit1 && step1 && cfg[CFG_IRQ1];
   assign irq_set[2] = lf_tick && act_en[2] && !clr_req[2] && step2 && cfg[CFG_MODE2] && toggle;
   assign irq_clr = (wr_intr && w_strb_q[0]) ? w_data_q[NUM_CTR-1:0] : '0;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_counter_irq_flag <= '0;
      end else begin
         o_counter_irq_flag <= irq_set | (o_counter_irq_flag & ~irq_clr);
      end
   end

   // control view with live status bits
   always_comb begin
      ctl_view = 32'h00000000;
      for (int i = 0; i < NUM_CTR; i++) begin
         ctl_view[i*CTL_STRIDE + CTL_EN] = en_bit[i];
         ctl_view[i*CTL_STRIDE + CTL_ENSTAT] = act_en[i];
         ctl_view[i*CTL_STRIDE + CTL_CLR] = clr_req[i];
      end
      ctl_view[CTL_LOCK_LSB +: 2] = lock;
   end

   // read decode
   always_comb begin
      next_rdata = 32'h00000000;
      next_rok = 1'b1;
      if (i_s_axi_araddr[7:0] == OFF_CNT_LOW) begin
         next_rdata = {cnt1, cnt0};
      end else if (i_s_axi_araddr[7:0] == OFF_CNT_HIGH) begin
         next_rdata = wide;
      end else if (i_s_axi_araddr[7:0] == OFF_MATCH) begin
         next_rdata = cmp;
      end else if (i_s_axi_araddr[7:0] == OFF_CONFIG) begin
         next_rdata = cfg;
      end else if (i_s_axi_araddr[7:0] == OFF_CTL) begin
         next_rdata = ctl_view;
      end else if (i_s_axi_araddr[7:0] == OFF_INTR) begin
         next_rdata = {{(32-NUM_CTR){1'b0}}, o_counter_irq_flag};
      end else begin
         next_rok = 1'b0;
      end
   end
   assign o_s_axi_arready = !o_s_axi_rvalid;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= next_rdata;
         o_s_axi_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   sequence cfg_write_s;
      wr_fire && (aw_addr_q == OFF_CONFIG);
   endsequence
   sequence lock_code1_s;
      wr_fire && (aw_addr_q == OFF_CTL) && w_strb_q[3] && (w_data_q[CTL_LOCK_LSB +: 2] == LOCK_CLR_B0);
   endsequence

   wide_step_a: assert property (lf_tick && act_en[2] && !clr_req[2] && !cfg[CFG_CHAIN12]
      |=> wide == $past(wide) + 32'h00000001) else $error("wide counter did not step");
   wide_idle_a: assert property (!lf_tick |=> $stable(wide))
      else $error("wide counter moved without a tick");
   toggle_flag_a: assert property (lf_tick && act_en[2] && !clr_req[2] && !cfg[CFG_CHAIN12]
      && cfg[CFG_MODE2] && toggle |=> o_counter_irq_flag[2]) else $error("toggle flag not raised");
   no_mode_flag_a: assert property (!cfg[CFG_MODE2] && !o_counter_irq_flag[2]
      |=> !o_counter_irq_flag[2]) else $error("toggle flag raised with mode off");
   enable_settle_a: assert property ($changed(act_en) |-> $past(lf_tick))
      else $error("enable took effect off a tick");
   status_lag_a: assert property (lf_tick && (en_s1 != act_en) |=> act_en == $past(en_s1))
      else $error("status did not follow enable");
   clear_req_a: assert property (lf_tick && clr_req[2] && !clr_set[2] |=> wide == 32'h00000000
      && !clr_req[2]) else $error("clear request not served");
   lock_hold_a: assert property (cfg_write_s and (locked) |=> $stable(cfg))
      else $error("config written while locked");
   lock_code_a: assert property (lock_code1_s |=> !lock[0] && lock[1] == $past(lock[1]))
      else $error("lock code 1 misbehaved");
   chain_wait_a: assert property (lf_tick && cfg[CFG_CHAIN01] && !hit0_q && !clr_req[1]
      |=> cnt1 == $past(cnt1)) else $error("chained counter stepped early");
   flag_w1c_a: assert property (o_counter_irq_flag[2] && !irq_set[2] && irq_clr[2]
      |=> !o_counter_irq_flag[2]) else $error("wide flag not cleared");
   chain_clear_a: assert property (lf_tick && hit0 && act_en[0] && clr_req[0] |=> hit0_q)
      else $error("clear at compare dropped the pending upper step");
endmodule
`default_nettype wire

// [tb/multi_counter_watchdog_ctl_test.sv]
// self-checking bench for the multi-counter watchdog control block
`default_nettype none
module multi_counter_watchdog_ctl_test import mcw_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // slow tick every four system cycles keeps the run short
   localparam int LFD = 4;
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [2:0] flag, ens;
   int failures, checks, cyc;

   mcw_ctl #(.ADDR_W(8), .LF_DIV(LFD)) i_mcw_ctl (
      .i_clk_sys(clk), .i_resetn(rstn),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_counter_irq_flag(flag), .o_counter_enabled_status(ens)
   );

   // closing report, reached from the main sequence or the timeout
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t resp %h expected %h", $time, got, exp);
      end
   endtask

   // write: handshakes judged at the falling edge, so the next rising edge acts on settled values
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge clk);
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      bready <= 1'h1;
      tb = 1'h0;
      while (!tb) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      chk_resp(r, er);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      logic ta, tr;
      logic [1:0] r;
      @(posedge clk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      tr = 1'h0;
      while (!tr) begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      chk_resp(r, er);
   endtask

   // polls control until the masked bits settle, then compares them
   task automatic poll_ctl(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      int n;
      n = 0;
      do begin
         rd(OFF_CTL, d, RESP_OKAY);
         n++;
      end while ((d & m) !== e && n < 12);
      chk_word(d & m, e);
   endtask

   task automatic wait_flag(input int i, output int c);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (flag[i] !== 1'h1 && n < 400);
      c = cyc;
   endtask

   // cycles between two flag sets; the first sighting may stem from a set-up change
   task automatic measure(input int i, output int p);
      int c0, c1, c2;
      wait_flag(i, c0);
      repeat (20) @(posedge clk);
      chk_word(32'(flag[i]), 32'h1);
      wr(OFF_INTR, 32'h1 << i, 4'h1, RESP_OKAY);
      wait_flag(i, c1);
      wr(OFF_INTR, 32'h1 << i, 4'h1, RESP_OKAY);
      wait_flag(i, c2);
      wr(OFF_INTR, 32'h1 << i, 4'h1, RESP_OKAY);
      p = c2 - c1;
   endtask

   task automatic test_reset;
      logic [31:0] d;
      rd(OFF_CONFIG, d, RESP_OKAY);
      chk_word(d, CFG_RESET);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'h0);
      rd(OFF_MATCH, d, RESP_OKAY);
      chk_word(d, MATCH_RESET);
      wr(OFF_CNT_HIGH, 32'h1234, 4'hF, RESP_OKAY);
      rd(OFF_CNT_HIGH, d, RESP_OKAY);
      chk_word(d, 32'h0);
      wr(8'h18, 32'h1, 4'hF, RESP_SLVERR);
      rd(8'h18, d, RESP_SLVERR);
      chk_word(d, 32'h0);
      $display("reset test done");
   endtask

   task automatic test_lock;
      logic [31:0] d;
      wr(OFF_CTL, 32'hC0000000, 4'h8, RESP_OKAY);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'hC0000000);
      wr(OFF_CONFIG, 32'h4, 4'hF, RESP_OKAY);
      rd(OFF_CONFIG, d, RESP_OKAY);
      chk_word(d, 32'h0);
      wr(OFF_MATCH, 32'h5, 4'hF, RESP_OKAY);
      rd(OFF_MATCH, d, RESP_OKAY);
      chk_word(d, 32'h0);
      wr(OFF_CTL, 32'h1, 4'h1, RESP_OKAY);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'hC0000000);
      wr(OFF_CTL, 32'h40000000, 4'h8, RESP_OKAY);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'h80000000);
      wr(OFF_CONFIG, 32'h4, 4'hF, RESP_OKAY);
      rd(OFF_CONFIG, d, RESP_OKAY);
      chk_word(d, 32'h0);
      wr(OFF_CTL, 32'h0, 4'h8, RESP_OKAY);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'h80000000);
      wr(OFF_CTL, 32'h80000000, 4'h8, RESP_OKAY);
      rd(OFF_CTL, d, RESP_OKAY);
      chk_word(d, 32'h0);
      wr(OFF_CONFIG, 32'h4, 4'hF, RESP_OKAY);
      rd(OFF_CONFIG, d, RESP_OKAY);
      chk_word(d, 32'h4);
      wr(OFF_CONFIG, 32'h0, 4'hF, RESP_OKAY);
      $display("lock test done");
   endtask

   task automatic test_wide;
      logic [31:0] v1, v2;
      wr(OFF_CTL, 32'h00010000, 4'h4, RESP_OKAY);
      poll_ctl(32'h00020000, 32'h00020000);
      chk_word(32'(ens), 32'h4);
      // reads taken exactly forty cycles apart span ten slow ticks
      rd(OFF_CNT_HIGH, v1, RESP_OKAY);
      repeat (37) @(posedge clk);
      rd(OFF_CNT_HIGH, v2, RESP_OKAY);
      chk_word(v2 - v1, 32'hA);
      $display("wide counter test done");
   endtask

   task automatic test_toggle;
      logic [31:0] d;
      int p;
      wr(OFF_CONFIG, 32'h0, 4'hF, RESP_OKAY);
      wr(OFF_INTR, 32'h4, 4'h1, RESP_OKAY);
      repeat (40) @(posedge clk);
      chk_word(32'(flag), 32'h0);
      for (int s = 2; s < 4; s++) begin
         wr(OFF_CONFIG, (32'(s) << 24) | 32'h00010000, 4'hF, RESP_OKAY);
         measure(2, p);
         chk_word(32'(p), 32'(LFD << s));
      end
      wr(OFF_CONFIG, 32'h1F010000, 4'hF, RESP_OKAY);
      wr(OFF_INTR, 32'h4, 4'h1, RESP_OKAY);
      repeat (60) @(posedge clk);
      rd(OFF_INTR, d, RESP_OKAY);
      chk_word(d & 32'h4, 32'h0);
      wr(OFF_CONFIG, 32'h0, 4'hF, RESP_OKAY);
      $display("toggle test done");
   endtask

   task automatic test_short;
      logic [31:0] d;
      int p;
      wr(OFF_MATCH, 32'h5, 4'hF, RESP_OKAY);
      wr(OFF_CONFIG, 32'h5, 4'hF, RESP_OKAY);
      wr(OFF_CTL, 32'h00010001, 4'h5, RESP_OKAY);
      poll_ctl(32'h2, 32'h2);
      measure(0, p);
      chk_word(32'(p), 32'(6 * LFD));
      for (int k = 0; k < 6; k++) begin
         rd(OFF_CNT_LOW, d, RESP_OKAY);
         chk_word(32'(d[15:0] <= 16'h5), 32'h1);
      end
      // clear request on the wide counter, which by now holds about a hundred ticks
      wr(OFF_CTL, 32'h00090001, 4'h5, RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(OFF_CNT_HIGH, d, RESP_OKAY);
      chk_word(32'(d < 32'h4), 32'h1);
      poll_ctl(32'h00080000, 32'h0);
      $display("short counter test done");
   endtask

   task automatic test_disable;
      logic [31:0] v1, v2;
      int n;
      wr(OFF_CTL, 32'h0, 4'h1, RESP_OKAY);
      chk_word(32'(ens[0]), 32'h1);
      n = 0;
      while (ens[0] !== 1'h0 && n < 12) begin
         @(negedge clk);
         n++;
      end
      chk_word(32'(ens[0]), 32'h0);
      rd(OFF_CNT_LOW, v1, RESP_OKAY);
      repeat (20) @(posedge clk);
      rd(OFF_CNT_LOW, v2, RESP_OKAY);
      chk_word(v2 & 32'hFFFF, v1 & 32'hFFFF);
      $display("disable test done");
   endtask

   task automatic test_chain;
      logic [31:0] v1, v2;
      wr(OFF_MATCH, 32'h00640003, 4'hF, RESP_OKAY);
      wr(OFF_CONFIG, 32'hC, 4'hF, RESP_OKAY);
      wr(OFF_CTL, 32'h00010909, 4'h3, RESP_OKAY);
      poll_ctl(32'h0202, 32'h0202);
      // 160 cycles are ten prescaler periods of four ticks
      rd(OFF_CNT_LOW, v1, RESP_OKAY);
      repeat (157) @(posedge clk);
      rd(OFF_CNT_LOW, v2, RESP_OKAY);
      chk_word((v2 >> 16) - (v1 >> 16), 32'hA);
      $display("chain test done");
   endtask

   // two clears sixteen cycles apart: the second meets the prescaler sitting at its compare value
   task automatic test_chain_clear;
      logic [31:0] d, v1, v2;
      wr(OFF_CTL, 32'h00010909, 4'h3, RESP_OKAY);
      repeat (12) @(posedge clk);
      wr(OFF_CTL, 32'h00010909, 4'h3, RESP_OKAY);
      repeat (10) @(posedge clk);
      rd(OFF_CNT_LOW, d, RESP_OKAY);
      chk_word(d >> 16, 32'h1);
      // upper-only clear one and a half prescaler periods later, away from the compare value
      repeat (7) @(posedge clk);
      wr(OFF_CTL, 32'h00010901, 4'h3, RESP_OKAY);
      repeat (6) @(posedge clk);
      rd(OFF_CNT_LOW, d, RESP_OKAY);
      chk_word(d >> 16, 32'h0);
      // second-to-wide chain: the wide counter waits for second-counter matches
      wr(OFF_CONFIG, 32'h80C, 4'hF, RESP_OKAY);
      rd(OFF_CNT_HIGH, v1, RESP_OKAY);
      repeat (37) @(posedge clk);
      rd(OFF_CNT_HIGH, v2, RESP_OKAY);
      chk_word(v2 - v1, 32'h0);
      $display("chain clear test done");
   endtask

   // system clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // cycle count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         give_verdict;
      end
   end

   // main sequence
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      test_reset;
      test_lock;
      test_wide;
      test_toggle;
      test_short;
      test_disable;
      test_chain;
      test_chain_clear;
      give_verdict;
   end
endmodule
`default_nettype wire
